// ### design/psfb_pkg.sv
// Package of constants and carrier types for the supply fault and status register bank
//
// Summary of operation
// - The bulk short flag sets when either bulk voltage is below the short level and holds until power-on reset.
// - The bulk 2 overvoltage flag sets when bulk 2 is above its limit and holds until power-on reset.
// - The bulk 1 overvoltage flag sets when bulk 1 is above its limit and holds until power-on reset.
// - The bulk mismatch flag sets when the two bulk regulations differ markedly and holds until power-on reset.
// - The bulk 2 undervoltage flag sets when bulk 2 is below its limit and holds until power-on reset.
// - The bulk 1 undervoltage flag sets when bulk 1 is below its limit and holds until power-on reset.
// - The bulk good bit reads as set while a bulk voltage sits at its nominal threshold.
// - Three sticky monitor flags for isolated, converter and bulk supplies set from their own inputs and stay set.
// - One status bit shows whether the input stage is wired in parallel or in series.
// - The bulk switch over-temperature bit is set while that temperature is too high and clears by itself.
// - Separate self-clearing over-temperature bits cover forward stage 2 and forward stage 1.
// - The auxiliary over-temperature bit follows its condition and clears by itself.
// - The ambient over-temperature bit follows its condition and clears by itself.
// - The summary over-temperature bit is the OR of temperature bits 15 down to 9.

package psfb_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_VENDOR_STATUS = 8'h74;
  localparam logic [7:0] ADDR_TEMP_STATUS = 8'h76;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h78;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h7a;

  // ----------------------------------------------------------------
  // Vendor status field positions
  // ----------------------------------------------------------------
  localparam int VS_SHORT = 14;
  localparam int VS_OV2 = 13;
  localparam int VS_OV1 = 12;
  localparam int VS_MISMATCH = 11;
  localparam int VS_UV2 = 10;
  localparam int VS_UV1 = 9;
  localparam int VS_GOOD = 8;
  localparam int VS_ISO_MON = 7;
  localparam int VS_CONV_MON = 6;
  localparam int VS_BULK_MON = 5;
  localparam int VS_SERIES = 1;

  // ----------------------------------------------------------------
  // Temperature status field positions
  // ----------------------------------------------------------------
  localparam int TS_SWITCH = 15;
  localparam int TS_FWD2 = 14;
  localparam int TS_FWD1 = 13;
  localparam int TS_XFMR2 = 12;
  localparam int TS_XFMR1 = 11;
  localparam int TS_AUX = 10;
  localparam int TS_AMBIENT = 9;
  localparam int TS_SUMMARY = 7;
  localparam int TS_OR_LO = 9;

  // ----------------------------------------------------------------
  // Interrupt event positions and reset values
  // ----------------------------------------------------------------
  localparam int EV_HOT = 15;
  localparam int EV_GOOD_LOST = 8;
  localparam logic [15:0] LATCH_MASK = 16'h7ee0;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } psfb_bus_req_t;

  typedef struct packed {
    logic bulk1_short;
    logic bulk2_short;
    logic bulk2_over;
    logic bulk1_over;
    logic mismatch;
    logic bulk2_under;
    logic bulk1_under;
    logic bulk_good;
    logic iso_mon;
    logic conv_mon;
    logic bulk_mon;
    logic input_series;
  } psfb_bulk_in_t;

  typedef struct packed {
    logic switch_hot;
    logic fwd2_hot;
    logic fwd1_hot;
    logic xfmr2_hot;
    logic xfmr1_hot;
    logic aux_hot;
    logic ambient_hot;
  } psfb_temp_in_t;

endpackage

// ### design/psfb_status_bank.sv
// Fault and status register bank of the bulk supply, with event interrupt
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module psfb_status_bank
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire psfb_pkg::psfb_bus_req_t bus,
  output logic [15:0] rdata,
  // Supply conditions, synchronous to mclk
  input wire psfb_pkg::psfb_bulk_in_t bulk_in,
  input wire psfb_pkg::psfb_temp_in_t temp_in,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Latched bulk faults
  // ----------------------------------------------------------------
  logic bulk_short_flag;
  logic bulk2_overvolt_flag;
  logic bulk1_overvolt_flag;
  logic bulk_mismatch_flag;
  logic bulk2_undervolt_flag;
  logic bulk1_undervolt_flag;
  logic isolated_supply_sticky;
  logic converter_supply_sticky;
  logic bulk_supply_sticky;
  logic bulk_good;
  logic input_series;

  // Only power-on reset clears these; nothing software does can
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      bulk_short_flag <= 1'b0;
      bulk2_overvolt_flag <= 1'b0;
      bulk1_overvolt_flag <= 1'b0;
      bulk_mismatch_flag <= 1'b0;
      bulk2_undervolt_flag <= 1'b0;
      bulk1_undervolt_flag <= 1'b0;
    end
    else
    begin
      if (bulk_in.bulk1_short || bulk_in.bulk2_short)
        bulk_short_flag <= 1'b1;
      if (bulk_in.bulk2_over)
        bulk2_overvolt_flag <= 1'b1;
      if (bulk_in.bulk1_over)
        bulk1_overvolt_flag <= 1'b1;
      if (bulk_in.mismatch)
        bulk_mismatch_flag <= 1'b1;
      if (bulk_in.bulk2_under)
        bulk2_undervolt_flag <= 1'b1;
      if (bulk_in.bulk1_under)
        bulk1_undervolt_flag <= 1'b1;
    end
  end

  // Supply monitor sticky bits, held after the input drops
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      isolated_supply_sticky <= 1'b0;
      converter_supply_sticky <= 1'b0;
      bulk_supply_sticky <= 1'b0;
    end
    else
    begin
      if (bulk_in.iso_mon)
        isolated_supply_sticky <= 1'b1;
      if (bulk_in.conv_mon)
        converter_supply_sticky <= 1'b1;
      if (bulk_in.bulk_mon)
        bulk_supply_sticky <= 1'b1;
    end
  end

  // Live levels, one flop so reads see a stable copy
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      bulk_good <= 1'b0;
      input_series <= 1'b0;
    end
    else
    begin
      bulk_good <= bulk_in.bulk_good;
      input_series <= bulk_in.input_series;
    end
  end

  // ----------------------------------------------------------------
  // Self-clearing temperature faults
  // ----------------------------------------------------------------
  logic bulk_switch_hot_flag;
  logic fwd_stage2_hot_flag;
  logic fwd_stage1_hot_flag;
  logic xfmr2_hot_flag;
  logic xfmr1_hot_flag;
  logic aux_hot_flag;
  logic ambient_hot_flag;
  logic any_hot_summary;
  logic any_hot_prev;

  // Each bit follows its condition and drops with it
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      bulk_switch_hot_flag <= 1'b0;
      fwd_stage2_hot_flag <= 1'b0;
      fwd_stage1_hot_flag <= 1'b0;
      xfmr2_hot_flag <= 1'b0;
      xfmr1_hot_flag <= 1'b0;
      aux_hot_flag <= 1'b0;
      ambient_hot_flag <= 1'b0;
    end
    else
    begin
      bulk_switch_hot_flag <= temp_in.switch_hot;
      fwd_stage2_hot_flag <= temp_in.fwd2_hot;
      fwd_stage1_hot_flag <= temp_in.fwd1_hot;
      xfmr2_hot_flag <= temp_in.xfmr2_hot;
      xfmr1_hot_flag <= temp_in.xfmr1_hot;
      aux_hot_flag <= temp_in.aux_hot;
      ambient_hot_flag <= temp_in.ambient_hot;
    end
  end

  // ----------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------
  logic [15:0] vendor_fault_status;
  logic [15:0] temperature_fault_status;

  // Vendor word; unused positions read as zero
  always_comb
  begin
    vendor_fault_status = psfb_pkg::RST_WORD;
    vendor_fault_status[psfb_pkg::VS_SHORT] = bulk_short_flag;
    vendor_fault_status[psfb_pkg::VS_OV2] = bulk2_overvolt_flag;
    vendor_fault_status[psfb_pkg::VS_OV1] = bulk1_overvolt_flag;
    vendor_fault_status[psfb_pkg::VS_MISMATCH] = bulk_mismatch_flag;
    vendor_fault_status[psfb_pkg::VS_UV2] = bulk2_undervolt_flag;
    vendor_fault_status[psfb_pkg::VS_UV1] = bulk1_undervolt_flag;
    vendor_fault_status[psfb_pkg::VS_GOOD] = bulk_good;
    vendor_fault_status[psfb_pkg::VS_ISO_MON] = isolated_supply_sticky;
    vendor_fault_status[psfb_pkg::VS_CONV_MON] = converter_supply_sticky;
    vendor_fault_status[psfb_pkg::VS_BULK_MON] = bulk_supply_sticky;
    vendor_fault_status[psfb_pkg::VS_SERIES] = input_series;
  end

  // Full sixteen bits, summary built from the same word it sits in
  always_comb
  begin
    temperature_fault_status = psfb_pkg::RST_WORD;
    temperature_fault_status[psfb_pkg::TS_SWITCH] = bulk_switch_hot_flag;
    temperature_fault_status[psfb_pkg::TS_FWD2] = fwd_stage2_hot_flag;
    temperature_fault_status[psfb_pkg::TS_FWD1] = fwd_stage1_hot_flag;
    temperature_fault_status[psfb_pkg::TS_XFMR2] = xfmr2_hot_flag;
    temperature_fault_status[psfb_pkg::TS_XFMR1] = xfmr1_hot_flag;
    temperature_fault_status[psfb_pkg::TS_AUX] = aux_hot_flag;
    temperature_fault_status[psfb_pkg::TS_AMBIENT] = ambient_hot_flag;
    temperature_fault_status[psfb_pkg::TS_SUMMARY] = any_hot_summary;
  end

  assign any_hot_summary = bulk_switch_hot_flag | fwd_stage2_hot_flag | fwd_stage1_hot_flag
    | xfmr2_hot_flag | xfmr1_hot_flag | aux_hot_flag | ambient_hot_flag;

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [15:0] irq_status;
  logic [15:0] irq_mask;
  logic [15:0] events;
  logic [15:0] vendor_prev;
  logic bulk_good_prev;

  // Previous images for edge detection
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      vendor_prev <= psfb_pkg::RST_WORD;
      bulk_good_prev <= 1'b0;
      any_hot_prev <= 1'b0;
    end
    else
    begin
      vendor_prev <= vendor_fault_status;
      bulk_good_prev <= bulk_good;
      any_hot_prev <= any_hot_summary;
    end
  end

  // Latch rises, loss of bulk good and the start of any overheat
  always_comb
  begin
    events = vendor_fault_status & ~vendor_prev & psfb_pkg::LATCH_MASK;
    events[psfb_pkg::EV_GOOD_LOST] = bulk_good_prev & ~bulk_good;
    events[psfb_pkg::EV_HOT] = any_hot_summary & ~any_hot_prev;
  end

  // Write one to clear; a fresh event in the same cycle wins
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      irq_status <= psfb_pkg::RST_WORD;
    else if (bus.wr && bus.addr == psfb_pkg::ADDR_IRQ_STATUS)
      irq_status <= (irq_status & ~bus.wdata) | events;
    else
      irq_status <= irq_status | events;
  end

  // Mask register, all sources off after reset
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      irq_mask <= psfb_pkg::RST_WORD;
    else if (bus.wr && bus.addr == psfb_pkg::ADDR_IRQ_MASK)
      irq_mask <= bus.wdata;
  end

  // Level output, falls as soon as the last unmasked bit is cleared
  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [15:0] next_rdata;

  // Decode; unmapped addresses and idle cycles give zero
  always_comb
  begin
    next_rdata = psfb_pkg::RST_WORD;
    if (bus.rd)
    begin
      unique case (bus.addr)
        psfb_pkg::ADDR_VENDOR_STATUS: next_rdata = vendor_fault_status;
        psfb_pkg::ADDR_TEMP_STATUS: next_rdata = temperature_fault_status;
        psfb_pkg::ADDR_IRQ_STATUS: next_rdata = irq_status;
        psfb_pkg::ADDR_IRQ_MASK: next_rdata = irq_mask;
        default: next_rdata = psfb_pkg::RST_WORD;
      endcase
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rdata <= psfb_pkg::RST_WORD;
    else
      rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // Latched bulk faults: set one cycle after the cause, held until reset
  property p_short_latch;
    (bulk_in.bulk1_short || bulk_in.bulk2_short)
      |=> vendor_fault_status[psfb_pkg::VS_SHORT] [*4];
  endproperty
  a_short_latch: assert property (p_short_latch) else $error("short flag not latched");

  property p_ov2_latch;
    bulk2_overvolt_flag |=> bulk2_overvolt_flag;
  endproperty
  a_ov2_latch: assert property (p_ov2_latch) else $error("ov2 flag dropped");

  property p_ov1_set;
    bulk_in.bulk1_over |=> vendor_fault_status[psfb_pkg::VS_OV1];
  endproperty
  a_ov1_set: assert property (p_ov1_set) else $error("ov1 flag not set");

  property p_mismatch_set;
    $rose(vendor_fault_status[psfb_pkg::VS_MISMATCH]) |-> $past(bulk_in.mismatch);
  endproperty
  a_mismatch_set: assert property (p_mismatch_set) else $error("mismatch flag without cause");

  property p_uv2_set;
    bulk_in.bulk2_under |=> bulk2_undervolt_flag ##1 bulk2_undervolt_flag;
  endproperty
  a_uv2_set: assert property (p_uv2_set) else $error("uv2 flag not held");

  property p_uv1_set;
    bulk_in.bulk1_under |=> vendor_fault_status[psfb_pkg::VS_UV1];
  endproperty
  a_uv1_set: assert property (p_uv1_set) else $error("uv1 flag not set");

  // Live bits skip the release edge, where their flops were still held in reset
  property p_good_follow;
    $past(rstn) |-> vendor_fault_status[psfb_pkg::VS_GOOD] == $past(bulk_in.bulk_good);
  endproperty
  a_good_follow: assert property (p_good_follow) else $error("bulk good mismatch");

  property p_mon_sticky;
    bulk_in.iso_mon |=> vendor_fault_status[psfb_pkg::VS_ISO_MON] [*3];
  endproperty
  a_mon_sticky: assert property (p_mon_sticky) else $error("iso monitor not sticky");

  property p_series;
    $past(rstn) |-> vendor_fault_status[psfb_pkg::VS_SERIES] == $past(bulk_in.input_series);
  endproperty
  a_series: assert property (p_series) else $error("series bit wrong");

  property p_switch_hot;
    $past(rstn) |-> temperature_fault_status[psfb_pkg::TS_SWITCH] == $past(temp_in.switch_hot);
  endproperty
  a_switch_hot: assert property (p_switch_hot) else $error("switch hot bit wrong");

  property p_fwd_hot;
    $past(rstn) |-> temperature_fault_status[psfb_pkg::TS_FWD2] == $past(temp_in.fwd2_hot)
      && temperature_fault_status[psfb_pkg::TS_FWD1] == $past(temp_in.fwd1_hot);
  endproperty
  a_fwd_hot: assert property (p_fwd_hot) else $error("forward stage hot bits wrong");

  property p_aux_hot;
    !temp_in.aux_hot |=> !temperature_fault_status[psfb_pkg::TS_AUX];
  endproperty
  a_aux_hot: assert property (p_aux_hot) else $error("aux hot bit stuck");

  property p_ambient_hot;
    temp_in.ambient_hot |=> temperature_fault_status[psfb_pkg::TS_AMBIENT];
  endproperty
  a_ambient_hot: assert property (p_ambient_hot) else $error("ambient hot bit missing");

  // Summary judged against the raw inputs, not against the word it sits in
  property p_summary;
    $past(rstn) |-> temperature_fault_status[psfb_pkg::TS_SUMMARY] == $past(|temp_in);
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit wrong");

  property p_temp_read;
    (bus.rd && bus.addr == psfb_pkg::ADDR_TEMP_STATUS)
      |=> rdata == $past(temperature_fault_status);
  endproperty
  a_temp_read: assert property (p_temp_read) else $error("temperature read wrong");

  // Read data stands only in the cycle after a read strobe
  property p_rdata_idle;
    !bus.rd |=> rdata == psfb_pkg::RST_WORD;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

  // Interrupt status: a fresh event survives a clear written in the same cycle
  property p_set_wins;
    (events != psfb_pkg::RST_WORD) |=> (irq_status & $past(events)) == $past(events);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("interrupt event lost");

  property p_good_lost;
    $fell(bulk_good) |=> irq_status[psfb_pkg::EV_GOOD_LOST];
  endproperty
  a_good_lost: assert property (p_good_lost) else $error("bulk good loss not flagged");

  property p_hot_event;
    $rose(any_hot_summary) |=> irq_status[psfb_pkg::EV_HOT];
  endproperty
  a_hot_event: assert property (p_hot_event) else $error("overheat start not flagged");

  // Main scenarios
  c_short_seen: cover property (bulk_in.bulk1_short ##1 vendor_fault_status[psfb_pkg::VS_SHORT]);
  c_hot_irq: cover property ($rose(any_hot_summary) ##1 irq);
  c_hot_clears: cover property (any_hot_summary ##[1:20] !any_hot_summary);
  c_vendor_read: cover property ((bus.rd && bus.addr == psfb_pkg::ADDR_VENDOR_STATUS)
    ##1 rdata != psfb_pkg::RST_WORD);
  c_set_wins: cover property (events[psfb_pkg::EV_HOT] && bus.wr
    && bus.addr == psfb_pkg::ADDR_IRQ_STATUS);

endmodule

`default_nettype wire

// ### verification/psfb_host_model.sv
// Host controller model that issues register reads and writes to the status bank
`timescale 1ns/1ps
`default_nettype none

module psfb_host_model
(
  // Clock
  input wire logic mclk,
  // Register port toward the bank
  output var psfb_pkg::psfb_bus_req_t bus
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Idle bus from time zero so no stray strobe leaks out of reset
  initial
  begin
    bus = '0;
  end

  // One-cycle write; a full idle cycle follows so strobes never merge
  task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
    @(posedge mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge mclk);
    bus <= '0;
  endtask

  // One-cycle read; the word shows on rdata in the cycle after the strobe
  task automatic read_reg(input logic [7:0] addr);
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
    @(posedge mclk);
    bus <= '0;
  endtask
endmodule
`default_nettype wire

// ### verification/psfb_status_bank_tb_top.sv
// Self-checking testbench of the supply fault and status register bank
`timescale 1ns/1ps
`default_nettype none

module psfb_status_bank_tb_top;
  logic mclk;
  logic rstn;
  psfb_pkg::psfb_bus_req_t bus;
  logic [15:0] rdata;
  logic [11:0] bulk_vec;
  logic [6:0] temp_vec;
  psfb_pkg::psfb_bulk_in_t bulk_in;
  psfb_pkg::psfb_temp_in_t temp_in;
  logic irq;
  logic [15:0] exp_q[$];
  logic rd_seen;
  logic [15:0] latched;
  logic [31:0] rnd;
  int fails;
  int check_count;
  // Vendor bit of each bulk input, in field order from the top
  int vbit[12] = '{14, 14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 1};

  assign bulk_in = psfb_pkg::psfb_bulk_in_t'(bulk_vec);
  assign temp_in = psfb_pkg::psfb_temp_in_t'(temp_vec);

  // ----------------------------------------------------------------
  // Design, host and clock
  // ----------------------------------------------------------------
  psfb_status_bank psfb_status_bank_i
  (
    .mclk(mclk),
    .rstn(rstn),
    .bus(bus),
    .rdata(rdata),
    .bulk_in(bulk_in),
    .temp_in(temp_in),
    .irq(irq)
  );

  psfb_host_model host_model_i
  (
    .mclk(mclk),
    .bus(bus)
  );

  always #25 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Note the expected word, then let the host read it
  task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
    exp_q.push_back(exp);
    host_model_i.read_reg(addr);
  endtask

  // Power cycle: the only way latched faults go away
  task automatic reset_dut;
    @(posedge mclk);
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    latched = 16'h0000;
  endtask

  // Random-length pulse on one bulk input; flags must outlive it
  task automatic pulse(input int k);
    @(posedge mclk);
    bulk_vec[11-k] <= 1'b1;
    repeat (1 + $urandom % 3) @(posedge mclk);
    bulk_vec[11-k] <= 1'b0;
    latched[vbit[k]] = 1'b1;
    cyc(2);
  endtask

  // ----------------------------------------------------------------
  // Monitor: each read result is matched to the oldest note
  // ----------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (rd_seen)
    begin
      if (exp_q.size() == 0)
      begin
        fails++;
        $display("wrong value at %0t ns: read with no expected word", $time);
      end
      else
        check(rdata, exp_q.pop_front());
    end
    rd_seen <= bus.rd;
  end

  // Watchdog so a hang still ends in the report
  initial
  begin
    cyc(20000);
    fails++;
    $display("wrong value at %0t ns: run did not finish", $time);
    stop_test;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    rstn = 1'b0;
    bulk_vec = '0;
    temp_vec = '0;
    rd_seen = 1'b0;
    latched = 16'h0000;
    fails = 0;
    check_count = 0;
    void'($urandom(32'h70c05088));
    cyc(12);
    rstn <= 1'b1;
    // Reset values, unmapped read
    rd(psfb_pkg::ADDR_VENDOR_STATUS, psfb_pkg::RST_WORD);
    rd(psfb_pkg::ADDR_TEMP_STATUS, psfb_pkg::RST_WORD);
    rd(psfb_pkg::ADDR_IRQ_STATUS, 16'h0000);
    rd(psfb_pkg::ADDR_IRQ_MASK, 16'h0000);
    rd(8'h40, 16'h0000);
    $display("test reset values done");
    // First short input alone, then a power cycle clears it
    pulse(0);
    rd(psfb_pkg::ADDR_VENDOR_STATUS, latched);
    reset_dut;
    rd(psfb_pkg::ADDR_VENDOR_STATUS, 16'h0000);
    // Every other latched flag, accumulating
    for (int k = 1; k < 11; k++)
    begin
      if (k == 7)
        continue;
      pulse(k);
      rd(psfb_pkg::ADDR_VENDOR_STATUS, latched);
    end
    // Read-only words and unmapped writes are ignored
    host_model_i.write_reg(psfb_pkg::ADDR_VENDOR_STATUS, 16'hffff);
    host_model_i.write_reg(psfb_pkg::ADDR_TEMP_STATUS, 16'hffff);
    host_model_i.write_reg(8'h40, 16'hffff);
    rd(psfb_pkg::ADDR_VENDOR_STATUS, latched);
    rd(psfb_pkg::ADDR_TEMP_STATUS, 16'h0000);
    rd(8'h40, 16'h0000);
    $display("test latched flags done");
    // Interrupt: events pending, masked, unmasked, cleared
    rd(psfb_pkg::ADDR_IRQ_STATUS, latched);
    check(16'(irq), 16'h0000);
    host_model_i.write_reg(psfb_pkg::ADDR_IRQ_MASK, latched);
    cyc(1);
    check(16'(irq), 16'h0001);
    rd(psfb_pkg::ADDR_IRQ_MASK, latched);
    host_model_i.write_reg(psfb_pkg::ADDR_IRQ_STATUS, latched & 16'hdfff);
    cyc(1);
    check(16'(irq), 16'h0001);
    rd(psfb_pkg::ADDR_IRQ_STATUS, 16'h2000);
    host_model_i.write_reg(psfb_pkg::ADDR_IRQ_STATUS, 16'h2000);
    cyc(1);
    check(16'(irq), 16'h0000);
    rd(psfb_pkg::ADDR_IRQ_STATUS, 16'h0000);
    rd(psfb_pkg::ADDR_VENDOR_STATUS, latched);
    $display("test interrupt done");
    // Live bits: bulk good and input wiring
    @(posedge mclk);
    bulk_vec[4] <= 1'b1;
    bulk_vec[0] <= 1'b1;
    cyc(2);
    rd(psfb_pkg::ADDR_VENDOR_STATUS, latched | 16'h0102);
    @(posedge mclk);
    bulk_vec[4] <= 1'b0;
    cyc(3);
    rd(psfb_pkg::ADDR_VENDOR_STATUS, latched | 16'h0002);
    rd(psfb_pkg::ADDR_IRQ_STATUS, 16'h0100);
    host_model_i.write_reg(psfb_pkg::ADDR_IRQ_STATUS, 16'h0100);
    @(posedge mclk);
    bulk_vec[0] <= 1'b0;
    cyc(2);
    rd(psfb_pkg::ADDR_VENDOR_STATUS, latched);
    $display("test live bits done");
    // Temperature: each bit alone, then random mixes, then all clear
    for (int i = 0; i < 15; i++)
    begin
      rnd = (i < 7) ? (32'h1 << i) : $urandom;
      @(posedge mclk);
      temp_vec <= rnd[6:0];
      cyc(2);
      rd(psfb_pkg::ADDR_TEMP_STATUS, {rnd[6:0], 1'b0, |rnd[6:0], 7'h00});
    end
    @(posedge mclk);
    temp_vec <= 7'h00;
    cyc(3);
    rd(psfb_pkg::ADDR_TEMP_STATUS, 16'h0000);
    rd(psfb_pkg::ADDR_IRQ_STATUS, 16'h8000);
    host_model_i.write_reg(psfb_pkg::ADDR_IRQ_MASK, 16'h8000);
    cyc(1);
    check(16'(irq), 16'h0001);
    host_model_i.write_reg(psfb_pkg::ADDR_IRQ_STATUS, 16'h8000);
    cyc(1);
    check(16'(irq), 16'h0000);
    // Overheat start lands in the same cycle as a clear of its bit: the start wins
    @(posedge mclk);
    temp_vec <= 7'h01;
    host_model_i.write_reg(psfb_pkg::ADDR_IRQ_STATUS, 16'h8000);
    rd(psfb_pkg::ADDR_IRQ_STATUS, 16'h8000);
    temp_vec <= 7'h00;
    check(16'(irq), 16'h0001);
    $display("test temperature done");
    // Power cycle clears latched flags and the mask
    reset_dut;
    rd(psfb_pkg::ADDR_VENDOR_STATUS, 16'h0000);
    rd(psfb_pkg::ADDR_IRQ_MASK, 16'h0000);
    check(16'(irq), 16'h0000);
    $display("test power cycle done");
    cyc(2);
    check(16'(exp_q.size()), 16'h0000);
    stop_test;
  end
endmodule
`default_nettype wire
